/* inc/tcb_regs.svh */
// Purpose: Offsets, field positions, reset values and counts of the timer bank
// Assumes: Included by bare name after the package
// Notes:   Expanded-bank offsets are the low four address bits
`ifndef TCB_REGS_SVH
`define TCB_REGS_SVH

// ---------------------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------------------
`define TCB_OFF_COMMON_CTRL  4'h1
`define TCB_OFF_WIDE_HOLD    4'h7
`define TCB_OFF_WIDE_CAP_LO  4'h8
`define TCB_OFF_WIDE_CAP_HI  4'h9
`define TCB_OFF_NAR_CAP_LO   4'ha
`define TCB_OFF_NAR_CAP_HI   4'hb
`define TCB_OFF_WIN_SEL      8'hfd
`define TCB_BANK_NORMAL      4'h0
`define TCB_BANK_TIMER       4'hd

// ---------------------------------------------------------------------------
// Fields of the common control register
// ---------------------------------------------------------------------------
`define TCB_CC_EDGE_HI       5
`define TCB_CC_EDGE_LO       4
`define TCB_CC_SUB_HI        3
`define TCB_CC_SUB_LO        2
`define TCB_CC_RISE          1
`define TCB_CC_FALL          0
`define TCB_SUB_NORMAL       2'h0
`define TCB_SUB_PINGPONG     2'h1
`define TCB_SUB_FORCE_LOW    2'h2
`define TCB_SUB_FORCE_HIGH   2'h3

// ---------------------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------------------
`define TCB_RST_BYTE         8'h00
`define TCB_CNT_RELOAD8      8'hff
`define TCB_CNT_RELOAD16     16'hffff
`define TCB_FILT_NONE        4'h0
`define TCB_FILT_SHORT       4'h4
`define TCB_FILT_LONG        4'h8

`endif

/* inc/tcb_pkg.sv */
// Purpose: Types shared by the timer capture and control bank
// Assumes: Nothing
// Notes:   Constants live in tcb_regs.svh
package tcb_pkg;

  typedef enum logic {
    TCB_WAIT_FIRST,
    TCB_COUNTING
  } tcb_cap_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       short_addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tcb_req_s;

  typedef struct packed {
    logic comparator_input_a;
    logic comparator_input_b;
    logic alternate_edge_input;
  } tcb_pins_s;

  typedef struct packed {
    logic narrow_timer_output;
    logic wide_timer_output;
    logic pingpong;
    logic comparators_on;
  } tcb_outs_s;

endpackage

/* hdl/tcb_sync_filter.sv */
// Purpose: Three-flop pin synchroniser with a programmable glitch filter
// Assumes: Pin is asynchronous to i_clock
// Notes:   A length of zero passes the synchronised level straight through
module tcb_sync_filter #(
  parameter int CW = 4
) (
  input  wire logic          i_clock,
  input  wire logic          i_nrst,
  input  wire logic          i_ce,
  input  wire logic          i_pin,
  input  wire logic [CW-1:0] i_len,
  output logic               o_level
);

  logic          s1_q;
  logic          s2_q;
  logic          s3_q;
  logic          stable_q;
  logic [CW-1:0] run_q;

  if (CW < 4) begin : g_chk
    $error("tcb_sync_filter: CW must be at least 4");
  end

  // ---------------------------------------------------------------------------
  // Synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      s1_q     <= 1'b0;
      s2_q     <= 1'b0;
      s3_q     <= 1'b0;
      stable_q <= 1'b0;
    end else if (i_ce) begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once the two later stages agree
      if (s2_q == s3_q) begin
        stable_q <= s3_q;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Glitch filter
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      run_q   <= '0;
      o_level <= 1'b0;
    end else if (i_ce) begin
      if (stable_q == o_level || i_len == '0) begin
        run_q   <= '0;
        o_level <= stable_q;
      end else if (run_q + 1'b1 >= i_len) begin
        run_q   <= '0;
        o_level <= stable_q;
      end else begin
        run_q <= run_q + 1'b1;
      end
    end
  end

endmodule

/* hdl/tcb_top.sv */
// Purpose: Register window, edge inputs and capture/hold/control registers
// Assumes: Register file port of the CPU; i_clock is the system clock
// Notes:   Both capture widths share one edge-driven state machine
// Operation
// - Selector high nibble picks the 16-byte working group among 256 bytes.
// - Selector low nibble picks expanded bank; only banks 0 and D exist, others read zero.
// - Low nibble zero gives normal file; 1..F swaps low sixteen registers.
// - Comparators are used only while the analog-enable bit is set.
// - Each comparator pin gives rising, falling or both-edge interrupts.
// - Timer edge detector takes comparator pin A or alternate pin.
// - Narrow high capture gets the count of the high interval.
// - Narrow low capture gets the count of the low interval.
// - Wide high capture holds the captured most significant byte.
// - Wide low capture holds the captured least significant byte.
// - Captures read back data; writes to them change nothing.
// - Wide hold register is a read/write byte.
// - Transmit bits 3:2: normal, ping-pong, forced low, forced high.
// - Demodulation bits 3:2: no filter, 4-cycle, 8-cycle, reserved.
// - Transmit bit 1 sets narrow output initial level, zero at reset.
// - Mode select zero is transmit, otherwise demodulation.
`include "tcb_regs.svh"
module tcb_top #(
  parameter int FILT_CW = 4
) (
  input  wire logic               i_clock,
  input  wire logic               i_nrst,
  input  wire logic               i_ce,
  input  wire tcb_pkg::tcb_req_s  i_req,
  output logic [7:0]              o_rdata,
  input  wire tcb_pkg::tcb_pins_s i_pins,
  input  wire logic               i_comparator_a_result,
  input  wire logic               i_comparator_b_result,
  input  wire logic               i_analog_enable,
  input  wire logic [1:0]         i_irq_edge_sel,
  input  wire logic               i_edge_src_alternate,
  input  wire logic [1:0]         i_mode_select,
  output logic [1:0]              o_comparator_irq,
  output tcb_pkg::tcb_outs_s      o_outs
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [7:0]        mem_q [256];
  logic [7:0]        win_sel_q;
  logic [5:2]        ctrl_q;
  logic [1:0]        init_q;
  logic              rise_flag_q;
  logic              fall_flag_q;
  logic [7:0]        hold_q;
  logic [7:0]        nar_hi_q;
  logic [7:0]        nar_lo_q;
  logic [7:0]        wide_hi_q;
  logic [7:0]        wide_lo_q;
  logic [7:0]        ncnt_q;
  logic [15:0]       wcnt_q;
  tcb_pkg::tcb_cap_e cap_state_q;
  logic [2:0]        lvl_prev_q;
  logic [7:0]        eff_addr;
  logic              expanded;
  logic              in_timer_bank;
  logic              demod;
  logic [3:0]        filt_len;
  logic [2:0]        raw_in;
  logic [2:0]        lvl;
  logic [2:0]        rise;
  logic [2:0]        fall;
  logic              t_rise;
  logic              t_fall;
  logic              t_hit;
  logic              ncap;
  logic              wr_timer;
  logic [7:0]        rd_val;

  if (FILT_CW < 4) begin : g_chk
    $error("tcb_top: FILT_CW too narrow for the 8-cycle filter");
  end

  // ---------------------------------------------------------------------------
  // Register window decode
  // ---------------------------------------------------------------------------
  always_comb begin
    // Short addresses take their group from the selector
    eff_addr = i_req.short_addr ? {win_sel_q[7:4], i_req.addr[3:0]}
                                : i_req.addr;
    expanded = (eff_addr[7:4] == 4'h0)
            && (win_sel_q[3:0] != `TCB_BANK_NORMAL);
    in_timer_bank = expanded
                 && (win_sel_q[3:0] == `TCB_BANK_TIMER);
    wr_timer = i_req.wr && in_timer_bank;
  end

  // Mode decode: any nonzero select is demodulation
  assign demod = (i_mode_select != 2'h0);

  assign filt_len = !demod ? `TCB_FILT_NONE
                  : ctrl_q[`TCB_CC_SUB_HI:`TCB_CC_SUB_LO] == 2'h1 ? `TCB_FILT_SHORT
                  : ctrl_q[`TCB_CC_SUB_HI:`TCB_CC_SUB_LO] == 2'h2 ? `TCB_FILT_LONG
                  : `TCB_FILT_NONE;

  // ---------------------------------------------------------------------------
  // Input pins
  // ---------------------------------------------------------------------------
  // Comparator results replace the digital pin only while enabled
  assign raw_in[0] = i_analog_enable ? i_comparator_a_result
                                     : i_pins.comparator_input_a;
  assign raw_in[1] = i_analog_enable ? i_comparator_b_result
                                     : i_pins.comparator_input_b;
  assign raw_in[2] = i_pins.alternate_edge_input;

  for (genvar g = 0; g < 3; g++) begin : g_pin
    tcb_sync_filter #(
      .CW(FILT_CW)
    ) tcb_sync_filter_inst (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_ce    (i_ce),
      .i_pin   (raw_in[g]),
      .i_len   (FILT_CW'(filt_len)),
      .o_level (lvl[g])
    );
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      lvl_prev_q <= 3'h0;
    end else if (i_ce) begin
      lvl_prev_q <= lvl;
    end
  end

  assign rise   = lvl & ~lvl_prev_q;
  assign fall   = ~lvl & lvl_prev_q;
  assign t_rise = i_edge_src_alternate ? rise[2] : rise[0];
  assign t_fall = i_edge_src_alternate ? fall[2] : fall[0];

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    case (sel)
      2'h0:    edge_hit = f;
      2'h1:    edge_hit = r;
      default: edge_hit = r | f;
    endcase
  endfunction

  assign t_hit = demod && edge_hit(ctrl_q[`TCB_CC_EDGE_HI:`TCB_CC_EDGE_LO], t_rise, t_fall);

  // ---------------------------------------------------------------------------
  // Comparator edge interrupts
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_comparator_irq <= 2'h0;
    end else if (i_ce) begin
      o_comparator_irq[0] <= edge_hit(i_irq_edge_sel, rise[0], fall[0]);
      o_comparator_irq[1] <= edge_hit(i_irq_edge_sel, rise[1], fall[1]);
    end
  end

  // ---------------------------------------------------------------------------
  // Selector, normal file and hold register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      win_sel_q <= `TCB_RST_BYTE;
    end else if (i_ce && i_req.wr && eff_addr == `TCB_OFF_WIN_SEL) begin
      win_sel_q <= i_req.wdata;
    end
  end

  // File contents are data, so they carry no reset
  always_ff @(posedge i_clock) begin
    if (i_ce && i_req.wr && !expanded && eff_addr != `TCB_OFF_WIN_SEL) begin
      mem_q[eff_addr] <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      hold_q <= `TCB_RST_BYTE;
    end else if (i_ce && wr_timer && eff_addr[3:0] == `TCB_OFF_WIDE_HOLD) begin
      hold_q <= i_req.wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Common control
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ctrl_q <= 4'h0;
      init_q <= 2'h0;
    end else if (i_ce && wr_timer && eff_addr[3:0] == `TCB_OFF_COMMON_CTRL) begin
      ctrl_q <= i_req.wdata[5:2];
      // Low bits are initial levels only in transmit operation
      if (!demod) begin
        init_q <= i_req.wdata[1:0];
      end
    end
  end

  // Edge flags: a new edge beats a same-cycle clear
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      rise_flag_q <= 1'b0;
      fall_flag_q <= 1'b0;
    end else if (i_ce) begin
      if (demod && t_rise) begin
        rise_flag_q <= 1'b1;
      end else if (demod && wr_timer && eff_addr[3:0] == `TCB_OFF_COMMON_CTRL
                   && i_req.wdata[`TCB_CC_RISE]) begin
        rise_flag_q <= 1'b0;
      end
      if (demod && t_fall) begin
        fall_flag_q <= 1'b1;
      end else if (demod && wr_timer && eff_addr[3:0] == `TCB_OFF_COMMON_CTRL
                   && i_req.wdata[`TCB_CC_FALL]) begin
        fall_flag_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Narrow capture
  // ---------------------------------------------------------------------------
  assign ncap = t_hit && cap_state_q == tcb_pkg::TCB_COUNTING;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cap_state_q <= tcb_pkg::TCB_WAIT_FIRST;
      ncnt_q      <= `TCB_CNT_RELOAD8;
      wcnt_q      <= `TCB_CNT_RELOAD16;
    end else if (i_ce) begin
      case (cap_state_q)
        tcb_pkg::TCB_WAIT_FIRST: begin
          ncnt_q <= `TCB_CNT_RELOAD8;
          wcnt_q <= `TCB_CNT_RELOAD16;
          if (t_hit) begin
            cap_state_q <= tcb_pkg::TCB_COUNTING;
          end
        end
        tcb_pkg::TCB_COUNTING: begin
          ncnt_q <= ncap ? `TCB_CNT_RELOAD8 : ncnt_q - 8'h01;
          wcnt_q <= ncap ? `TCB_CNT_RELOAD16 : wcnt_q - 16'h0001;
          if (!demod) begin
            cap_state_q <= tcb_pkg::TCB_WAIT_FIRST;
          end
        end
        default: cap_state_q <= tcb_pkg::TCB_WAIT_FIRST;
      endcase
    end
  end

  // Captures ignore software writes entirely
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      nar_hi_q <= `TCB_RST_BYTE;
      nar_lo_q <= `TCB_RST_BYTE;
    end else if (i_ce && ncap) begin
      if (t_fall) begin
        nar_hi_q <= ~ncnt_q;
      end else begin
        nar_lo_q <= ~ncnt_q;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Wide capture
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wide_hi_q <= `TCB_RST_BYTE;
      wide_lo_q <= `TCB_RST_BYTE;
    end else if (i_ce && ncap) begin
      wide_hi_q <= ~wcnt_q[15:8];
      wide_lo_q <= ~wcnt_q[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_val = `TCB_RST_BYTE;
    if (in_timer_bank) begin
      case (eff_addr[3:0])
        `TCB_OFF_COMMON_CTRL: rd_val = {2'h0, ctrl_q, demod ? {rise_flag_q, fall_flag_q} : init_q};
        `TCB_OFF_WIDE_HOLD:   rd_val = hold_q;
        `TCB_OFF_WIDE_CAP_LO: rd_val = wide_lo_q;
        `TCB_OFF_WIDE_CAP_HI: rd_val = wide_hi_q;
        `TCB_OFF_NAR_CAP_LO:  rd_val = nar_lo_q;
        `TCB_OFF_NAR_CAP_HI:  rd_val = nar_hi_q;
        default:              rd_val = `TCB_RST_BYTE;
      endcase
    end else if (!expanded) begin
      rd_val = (eff_addr == `TCB_OFF_WIN_SEL) ? win_sel_q : mem_q[eff_addr];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_rdata <= `TCB_RST_BYTE;
    end else if (i_ce && i_req.rd) begin
      o_rdata <= rd_val;
    end
  end

  // ---------------------------------------------------------------------------
  // Timer outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_outs <= '0;
    end else if (i_ce) begin
      o_outs.narrow_timer_output <= !demod && init_q[1];
      o_outs.pingpong <= !demod && ctrl_q[3:2] == `TCB_SUB_PINGPONG;
      case (ctrl_q[3:2])
        `TCB_SUB_FORCE_LOW:  o_outs.wide_timer_output <= 1'b0;
        `TCB_SUB_FORCE_HIGH: o_outs.wide_timer_output <= !demod;
        default:             o_outs.wide_timer_output <= !demod && init_q[0];
      endcase
      o_outs.comparators_on <= i_analog_enable;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  group_sel_a: assert property (i_req.short_addr |-> eff_addr[7:4] == win_sel_q[7:4])
    else $error("short address left its working group");
  bank_swap_a: assert property (i_ce && i_req.rd && i_req.short_addr && in_timer_bank
    && i_req.addr[3:0] == `TCB_OFF_NAR_CAP_HI |-> ##1 o_rdata == $past(nar_hi_q))
    else $error("bank D read did not return narrow high capture");
  other_bank_a: assert property (i_ce && i_req.rd && expanded && !in_timer_bank
    |-> ##1 o_rdata == 8'h00)
    else $error("unimplemented bank did not read zero");
  analog_sel_a: assert property (!i_analog_enable |-> raw_in[0] == i_pins.comparator_input_a)
    else $error("comparator used while disabled");
  src_sel_a: assert property (i_edge_src_alternate |-> t_rise == rise[2] && t_fall == fall[2])
    else $error("timer edge not from alternate pin");
  cap_high_a: assert property (i_ce && ncap && t_fall |-> ##1 nar_hi_q == ~$past(ncnt_q))
    else $error("high interval not captured");
  cap_low_a: assert property (i_ce && ncap && t_rise |-> ##1 nar_lo_q == ~$past(ncnt_q))
    else $error("low interval not captured");
  wide_cap_a: assert property (i_ce && ncap |-> ##1 {wide_hi_q, wide_lo_q} == ~$past(wcnt_q))
    else $error("wide capture bytes wrong");
  cap_ro_a: assert property (i_ce && wr_timer && !ncap |-> ##1 $stable(nar_hi_q))
    else $error("write changed a capture register");
  hold_rw_a: assert property (i_ce && wr_timer && eff_addr[3:0] == `TCB_OFF_WIDE_HOLD
    |-> ##1 hold_q == $past(i_req.wdata))
    else $error("hold register not written");
  force_out_a: assert property (i_ce && !demod && ctrl_q[3:2] == `TCB_SUB_FORCE_HIGH
    |-> ##1 o_outs.wide_timer_output)
    else $error("wide output not forced high");
  filt_len_a: assert property (demod && ctrl_q[3:2] == 2'h1 |-> filt_len == 4'h4)
    else $error("short filter length wrong");
  init_lvl_a: assert property (i_ce && !demod |-> ##1 o_outs.narrow_timer_output == $past(init_q[1]))
    else $error("narrow output initial level wrong");

  capture_c:  cover property (ncap ##[1:50] ncap);
  wide_c:     cover property (ncap ##1 wide_lo_q != 8'h00);
  bank_rd_c:  cover property (i_req.rd && in_timer_bank);
  irq_c:      cover property (o_comparator_irq[0]);

endmodule

/* dv/tcb_pin_model.sv */
// Purpose: Far-side model of the comparator and timer edge pins
// Assumes: Levels are commanded by the bench at clock edges
// Notes:   Pins move mid-cycle, as true asynchronous sources would
module tcb_pin_model (
  input  wire logic          i_clock,
  input  wire logic [4:0]    i_cmd,
  output tcb_pkg::tcb_pins_s o_pins,
  output logic               o_res_a,
  output logic               o_res_b
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_pins  = '0;
    o_res_a = 1'b0;
    o_res_b = 1'b0;
  end

  // Offset from the edge so no flop samples the pin in the same step
  always @(posedge i_clock) begin
    #37;
    o_pins.comparator_input_a   <= i_cmd[0];
    o_pins.comparator_input_b   <= i_cmd[1];
    o_pins.alternate_edge_input <= i_cmd[2];
    o_res_a                     <= i_cmd[3];
    o_res_b                     <= i_cmd[4];
  end
endmodule

/* dv/timer_capture_control_bank_tb.sv */
// Purpose: Self-checking bench of the timer capture and control bank
// Assumes: Clock enable held high throughout
// Notes:   Capture figures allow two cycles for pin synchroniser slack
module timer_capture_control_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic               i_clock;
  logic               i_nrst;
  tcb_pkg::tcb_req_s  req;
  tcb_pkg::tcb_pins_s pins;
  tcb_pkg::tcb_outs_s outs;
  logic [7:0]         rdata;
  logic               res_a;
  logic               res_b;
  logic               ana;
  logic               alt_src;
  logic [1:0]         irq;
  logic [1:0]         irq_sel;
  logic [1:0]         mode;
  logic [4:0]         pcmd;
  logic [7:0]         d;
  int                 fails;
  int                 num_checks;
  int                 irqs;
  int                 h;
  int                 l;
  int                 flt[4][3] = '{'{1, 2, 0}, '{2, 5, 0}, '{2, 14, 2}, '{0, 4, 2}};

  tcb_top tcb_top_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_ce(1'b1), .i_req(req),
    .o_rdata(rdata), .i_pins(pins), .i_comparator_a_result(res_a),
    .i_comparator_b_result(res_b), .i_analog_enable(ana), .i_irq_edge_sel(irq_sel),
    .i_edge_src_alternate(alt_src), .i_mode_select(mode), .o_comparator_irq(irq),
    .o_outs(outs));
  tcb_pin_model tcb_pin_model_inst (.i_clock(i_clock), .i_cmd(pcmd), .o_pins(pins),
    .o_res_a(res_a), .o_res_b(res_b));

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  always @(posedge i_clock) irqs <= irqs + int'(irq[0] === 1'b1) + int'(irq[1] === 1'b1);

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic acc(logic [7:0] a, logic s, logic w, logic [7:0] wd);
    @(posedge i_clock);
    req <= '{addr: a, short_addr: s, wr: w, rd: !w, wdata: wd};
    @(posedge i_clock);
    req <= '0;
    @(posedge i_clock);
  endtask

  task automatic getr(logic [7:0] a, logic s);
    acc(a, s, 1'b0, 8'h00);
    #1;
    d = rdata;
    @(posedge i_clock);
  endtask

  task automatic rd(logic [7:0] a, logic s, string what, logic [7:0] exp);
    getr(a, s);
    check(what, d, exp);
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge i_clock);
  endtask

  function automatic logic near(int a, int b);
    return (a - b <= 2) && (b - a <= 2);
  endfunction

  task automatic final_report;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    #(100 * 20000);
    fails++;
    final_report();
  end

  initial begin
    fails = 0; num_checks = 0; irqs = 0; d = $urandom(32'h8e2ecc8b);
    i_nrst = 1'b0; req = '0; ana = 1'b0; irq_sel = 2'h0; alt_src = 1'b0; mode = 2'h0;
    pcmd = 5'h00;
    cyc(20);
    i_nrst <= 1'b1;
    acc(8'hfd, 1'b0, 1'b1, 8'h0d);
    rd(8'hfd, 1'b0, "selector", 8'h0d);
    for (int a = 0; a < 16; a++) rd(a[7:0], 1'b1, "reset byte", 8'h00);
    for (int i = 0; i < 4; i++) begin
      l = $urandom_range(1, 255);
      acc(8'h07, 1'b1, 1'b1, l[7:0]);
      rd(8'h07, 1'b1, "hold", l[7:0]);
      acc(8'h08 + i[7:0], 1'b1, 1'b1, ~l[7:0]);
      rd(8'h08 + i[7:0], 1'b1, "capture", 8'h00);
    end
    acc(8'hfd, 1'b0, 1'b1, 8'h0f);
    acc(8'h07, 1'b1, 1'b1, 8'h5a);
    rd(8'h07, 1'b1, "empty bank", 8'h00);
    h = $urandom_range(1, 14);
    acc(8'hfd, 1'b0, 1'b1, {h[3:0], 4'h0});
    acc(8'h07, 1'b1, 1'b1, 8'hc3);
    rd({h[3:0], 4'h7}, 1'b0, "group byte", 8'hc3);
    acc(8'hfd, 1'b0, 1'b1, 8'h0d);
    rd(8'h07, 1'b1, "hold kept", l[7:0]);
    for (int s = 0; s < 4; s++) begin
      d = {4'h0, s[1:0], 2'($urandom_range(0, 3))};
      acc(8'h01, 1'b1, 1'b1, d);
      cyc(2);
      check("wide out", outs.wide_timer_output, s == 2 ? 1'b0 : s == 3 ? 1'b1 : d[0]);
      check("ping-pong", outs.pingpong, s == 1);
      check("narrow out", outs.narrow_timer_output, d[1]);
    end
    for (int s = 0; s < 3; s++) begin
      irq_sel <= s[1:0]; h = irqs;
      pcmd[1:0] <= 2'h3; cyc(12);
      pcmd[1:0] <= 2'h0; cyc(12);
      check("edge irq", 16'(irqs - h), s == 2 ? 16'h4 : 16'h2);
    end
    ana <= 1'b1; irq_sel <= 2'h1; h = irqs; pcmd[4:3] <= 2'h3; cyc(12);
    check("comparators on", outs.comparators_on, 1'b1);
    check("analog irq", 16'(irqs - h), 16'h2);
    ana <= 1'b0; pcmd[4:3] <= 2'h0; irq_sel <= 2'h2; mode <= 2'h1; cyc(12);
    check("comparators off", outs.comparators_on, 1'b0);
    for (int i = 0; i < 4; i++) begin
      acc(8'h01, 1'b1, 1'b1, {4'h2, 2'(flt[i][0]), 2'h3});
      h = irqs; pcmd[0] <= 1'b1; cyc(flt[i][1]);
      pcmd[0] <= 1'b0; cyc(25);
      check("filtered irq", 16'(irqs - h), 16'(flt[i][2]));
    end
    check("demod narrow out", outs.narrow_timer_output, 1'b0);
    alt_src <= 1'b1; h = $urandom_range(20, 200); l = $urandom_range(20, 200);
    pcmd[2] <= 1'b1; cyc(30);
    pcmd[2] <= 1'b0; cyc(h);
    pcmd[2] <= 1'b1; cyc(l);
    pcmd[2] <= 1'b0; cyc(20);
    getr(8'h0b, 1'b1);
    check("narrow high", near(d, l), 1'b1);
    getr(8'h0a, 1'b1);
    check("narrow low", near(d, h), 1'b1);
    getr(8'h08, 1'b1);
    check("wide low", near(d, l), 1'b1);
    rd(8'h09, 1'b1, "wide high", 8'h00);
    rd(8'h01, 1'b1, "edge flags", 8'h23);
    final_report();
  end
endmodule
